// ---- core/idw_pkg.sv ----
// Behaviour
// - Major word: ATA-1, ATA-2 set; bit0 zero
// - Word 81 returns the minor version
// - Word 82 reports per-command support bits
// - Word 83: 15 clear, 14 set, bit0 microcode
// - Word 84: 15 clear, 14 set, rest zero
// - Word 85 enabled bits, bit11 write-verify
// - Words 86/87 signature; 86 bit0 microcode
// - Word 88 high: at most one selected mode bit
// - Word 88 low: supported mode level bits
// - Word 128 bit8 security level, reserved zero
// - Word 128 bits 4..0 security status
// - Word 131 bit0 zero when no-spin enabled
// - Ultra DMA valid flag only when consistent
package idw_pkg;
  // Wishbone byte offsets
  localparam logic [7:0] ADDR_VERSION  = 8'h00;
  localparam logic [7:0] ADDR_SUPPORT  = 8'h04;
  localparam logic [7:0] ADDR_ENABLE   = 8'h08;
  localparam logic [7:0] ADDR_UDMA     = 8'h0c;
  localparam logic [7:0] ADDR_SECURITY = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  // Record word indices
  localparam logic [7:0] W_MAJOR = 8'h50;
  localparam logic [7:0] W_MINOR = 8'h51;
  localparam logic [7:0] W_SUP1  = 8'h52;
  localparam logic [7:0] W_SUP2  = 8'h53;
  localparam logic [7:0] W_EXT   = 8'h54;
  localparam logic [7:0] W_EN1   = 8'h55;
  localparam logic [7:0] W_EN2   = 8'h56;
  localparam logic [7:0] W_EN3   = 8'h57;
  localparam logic [7:0] W_UDMA  = 8'h58;
  localparam logic [7:0] W_SEC   = 8'h80;
  localparam logic [7:0] W_SPIN  = 8'h83;
  // Field positions
  localparam int BIT_ATA1      = 1;
  localparam int BIT_ATA2      = 2;
  localparam int BIT_SIG_ONE   = 14;
  localparam int BIT_SIG_ZERO  = 15;
  localparam int BIT_SUP_RSVD  = 11;
  localparam int BIT_MCODE     = 0;
  localparam int BIT_SEC_LEVEL = 8;
  localparam int UDMA_SEL_LSB  = 8;
  localparam int REG_MCODE     = 16;
  localparam int REG_NOSPIN    = 16;
  localparam int REG_ATA_LSB   = 16;
  localparam int REG_SEL_LSB   = 2;
  localparam int STS_CNT_LSB   = 8;
  localparam int STS_IDX_LSB   = 16;
  // Reset values
  localparam logic [15:0] RST_MINOR   = 16'h0000;
  localparam logic [1:0]  RST_ATA_HI  = 2'h0;
  localparam logic [15:0] RST_SUPPORT = 16'h0000;
  localparam logic [15:0] RST_ENABLE  = 16'h0000;
  localparam logic [1:0]  RST_UDMA    = 2'h0;
  localparam logic [4:0]  RST_SEC_ST  = 5'h00;
endpackage

// ---- core/idw_core.sv ----
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module idw_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  output var  logic        ack_o,
  input  wire logic        word_rd_i,
  input  wire logic [7:0]  word_idx_i,
  output var  logic [15:0] word_data_o,
  output var  logic        word_ack_o,
  output var  logic        udma_valid_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [15:0] minor;
    logic [1:0]  ata_hi;
    logic [15:0] sup;
    logic        mcode;
    logic [15:0] en;
    logic [1:0]  udma_sup;
    logic [1:0]  udma_sel;
    logic        sec_lvl;
    logic [4:0]  sec_st;
    logic        no_spin;
    logic        wack;
    logic [15:0] wdata;
    logic [7:0]  widx;
    logic [7:0]  wcnt;
    logic        uvalid;
  } idw_state_type;

  idw_state_type st_q;
  idw_state_type st_d;

  logic bus_req;
  assign bus_req = cyc_i && stb_i && !st_q.ack;

  // Writes wait for the ack edge, where the master samples the answer
  logic bus_wr;
  assign bus_wr = cyc_i && stb_i && we_i && st_q.ack;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Code 0 means nothing; codes 1..3 stand for modes 0..2
  function automatic logic [2:0] mode_bits(input logic [1:0] code, input logic upto);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (upto ? (code > 2'(i)) : (code == 2'(i + 1))) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // Consistent when something is supported and any selection lies within it
  function automatic logic udma_ok(input logic [1:0] sup, input logic [1:0] sel);
    return (sup != 2'h0) && (sel <= sup);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a, input idw_state_type s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      idw_pkg::ADDR_VERSION: begin
        r[15:0] = s.minor;
        r[idw_pkg::REG_ATA_LSB +: 2] = s.ata_hi;
      end
      idw_pkg::ADDR_SUPPORT: begin
        r[15:0] = s.sup;
        r[idw_pkg::REG_MCODE] = s.mcode;
      end
      idw_pkg::ADDR_ENABLE: begin
        r[15:0] = s.en;
      end
      idw_pkg::ADDR_UDMA: begin
        r[1:0] = s.udma_sup;
        r[idw_pkg::REG_SEL_LSB +: 2] = s.udma_sel;
      end
      idw_pkg::ADDR_SECURITY: begin
        r[4:0] = s.sec_st;
        r[idw_pkg::BIT_SEC_LEVEL] = s.sec_lvl;
        r[idw_pkg::REG_NOSPIN] = s.no_spin;
      end
      idw_pkg::ADDR_STATUS: begin
        r[0] = s.uvalid;
        r[idw_pkg::STS_CNT_LSB +: 8] = s.wcnt;
        r[idw_pkg::STS_IDX_LSB +: 8] = s.widx;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction

  function automatic logic [15:0] rec_word(input logic [7:0] idx, input idw_state_type s);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      idw_pkg::W_MAJOR: begin
        w[idw_pkg::BIT_ATA1] = 1'b1;
        w[idw_pkg::BIT_ATA2] = 1'b1;
        w[4:3] = s.ata_hi;
      end
      idw_pkg::W_MINOR: begin
        w = s.minor;
      end
      idw_pkg::W_SUP1: begin
        w = s.sup;
        w[idw_pkg::BIT_SUP_RSVD] = 1'b0;
      end
      idw_pkg::W_SUP2, idw_pkg::W_EN2: begin
        w[idw_pkg::BIT_SIG_ONE] = 1'b1;
        w[idw_pkg::BIT_MCODE] = s.mcode;
      end
      idw_pkg::W_EXT, idw_pkg::W_EN3: begin
        w[idw_pkg::BIT_SIG_ONE] = 1'b1;
      end
      idw_pkg::W_EN1: begin
        w = s.en;
      end
      idw_pkg::W_UDMA: begin
        if (s.udma_sel <= s.udma_sup) begin
          w[idw_pkg::UDMA_SEL_LSB +: 3] = mode_bits(s.udma_sel, 1'b0);
        end
        w[2:0] = mode_bits(s.udma_sup, 1'b1);
      end
      idw_pkg::W_SEC: begin
        w[idw_pkg::BIT_SEC_LEVEL] = s.sec_lvl;
        w[4:0] = s.sec_st;
      end
      idw_pkg::W_SPIN: begin
        w[0] = !s.no_spin;
      end
      default: begin
        w = 16'h0000;
      end
    endcase
    return w;
  endfunction

  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    st_d = st_q;
    st_d.ack = bus_req;
    st_d.wack = word_rd_i;
    st_d.uvalid = udma_ok(st_q.udma_sup, st_q.udma_sel);
    if (word_rd_i) begin
      st_d.wdata = rec_word(word_idx_i, st_q);
      st_d.widx = word_idx_i;
      st_d.wcnt = st_q.wcnt + 8'h01;
    end
    if (bus_req) begin
      st_d.rdat = reg_read(adr_i, st_q);
    end
    if (bus_wr) begin
      m = merge(reg_read(adr_i, st_q), dat_i, sel_i);
      case (adr_i)
        idw_pkg::ADDR_VERSION: begin
          st_d.minor = m[15:0];
          st_d.ata_hi = m[idw_pkg::REG_ATA_LSB +: 2];
        end
        idw_pkg::ADDR_SUPPORT: begin
          st_d.sup = m[15:0];
          st_d.mcode = m[idw_pkg::REG_MCODE];
        end
        idw_pkg::ADDR_ENABLE: begin
          st_d.en = m[15:0];
        end
        idw_pkg::ADDR_UDMA: begin
          st_d.udma_sup = m[1:0];
          st_d.udma_sel = m[idw_pkg::REG_SEL_LSB +: 2];
        end
        idw_pkg::ADDR_SECURITY: begin
          st_d.sec_st = m[4:0];
          st_d.sec_lvl = m[idw_pkg::BIT_SEC_LEVEL];
          st_d.no_spin = m[idw_pkg::REG_NOSPIN];
        end
        default: begin
          st_d.minor = st_q.minor;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.minor <= idw_pkg::RST_MINOR;
      st_q.ata_hi <= idw_pkg::RST_ATA_HI;
      st_q.sup <= idw_pkg::RST_SUPPORT;
      st_q.en <= idw_pkg::RST_ENABLE;
      st_q.udma_sup <= idw_pkg::RST_UDMA;
      st_q.udma_sel <= idw_pkg::RST_UDMA;
      st_q.sec_st <= idw_pkg::RST_SEC_ST;
    end else begin
      st_q <= st_d;
    end
  end

  assign dat_o = st_q.rdat;
  assign ack_o = st_q.ack;
  assign word_data_o = st_q.wdata;
  assign word_ack_o = st_q.wack;
  assign udma_valid_o = st_q.uvalid;

  sequence s_word_req(logic [7:0] idx);
    word_rd_i && (word_idx_i == idx);
  endsequence

  sequence s_bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  a_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_req |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single cycle pulse");

  a_major_word_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_MAJOR) |=> word_ack_o && (word_data_o[2:0] == 3'b110)
      && (word_data_o[15:5] == 11'h000))
    else $error("major version word wrong");

  a_minor_word_value: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_MINOR) |=> word_data_o == $past(st_q.minor))
    else $error("minor version word wrong");

  a_support_word_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_SUP1) |=> (word_data_o[11] == 1'b0)
      && (word_data_o[10:0] == $past(st_q.sup[10:0])))
    else $error("support word wrong");

  a_word83_signature: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_SUP2) |=> (word_data_o[15:1] == 15'h2000)
      && (word_data_o[0] == $past(st_q.mcode)))
    else $error("word 83 wrong");

  a_word84_signature: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_EXT) |=> word_data_o == 16'h4000)
    else $error("word 84 wrong");

  a_enable_word_value: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_EN1) |=> word_data_o == $past(st_q.en))
    else $error("enable word wrong");

  a_word87_signature: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_EN3) |=> word_data_o == 16'h4000)
    else $error("word 87 wrong");

  a_udma_select_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_UDMA) |=> $onehot0(word_data_o[15:8])
      && (word_data_o[15:11] == 5'h00))
    else $error("ultra dma select bits wrong");

  a_udma_support_low: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_UDMA) |=> (word_data_o[7:3] == 5'h00)
      && (word_data_o[0] == ($past(st_q.udma_sup) != 2'h0)))
    else $error("ultra dma support bits wrong");

  a_security_word: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_SEC) |=> (word_data_o[15:9] == 7'h00) && (word_data_o[7:5] == 3'h0)
      && (word_data_o[8] == $past(st_q.sec_lvl)) && (word_data_o[4:0] == $past(st_q.sec_st)))
    else $error("security word wrong");

  a_spin_bit_value: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_SPIN) |=> word_data_o == {15'h0000, !$past(st_q.no_spin)})
    else $error("spin word wrong");

  a_udma_valid_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (udma_valid_o == udma_ok($past(st_q.udma_sup), $past(st_q.udma_sel))))
    else $error("ultra dma valid flag wrong");

  a_reserved_words_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    word_rd_i && (word_idx_i > idw_pkg::W_SPIN) |=> word_ack_o && (word_data_o == 16'h0000))
    else $error("reserved word not zero");

  a_word86_signature: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_EN2) |=> (word_data_o[15:1] == 15'h2000)
      && (word_data_o[0] == $past(st_q.mcode)))
    else $error("word 86 wrong");

  a_security_status_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_req(idw_pkg::W_SEC) |=> word_ack_o && (word_data_o[4:0] == $past(st_q.sec_st)))
    else $error("security status bits wrong");

  a_write_on_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && we_i && ack_o && (adr_i == idw_pkg::ADDR_ENABLE) && (sel_i == 4'hf)
      |=> st_q.en == $past(dat_i[15:0]))
    else $error("write not applied at ack edge");

  a_no_early_write: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o && we_i && (adr_i == idw_pkg::ADDR_ENABLE)
      |=> st_q.en == $past(st_q.en))
    else $error("write applied before ack");

  a_word_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    word_ack_o == $past(word_rd_i))
    else $error("record ack not one cycle after request");

  a_word_data_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !word_rd_i |=> $stable(word_data_o))
    else $error("record word changed without request");

  a_read_data_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i && !ack_o) |=> $stable(dat_o))
    else $error("read data changed without access");

  a_status_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    word_rd_i |=> st_q.wcnt == $past(st_q.wcnt) + 8'h01)
    else $error("record read count wrong");

endmodule
`default_nettype wire

// ---- test/idw_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module idw_host (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [7:0]  idx_i,
  input  wire logic        word_ack_i,
  input  wire logic [15:0] word_data_i,
  output logic             word_rd_o,
  output logic [7:0]       word_idx_o,
  output logic             notify_ok_o
);
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  pend_q = 8'h00;
  logic [15:0] sup1_q = 16'h0000;
  logic [15:0] sup2_q = 16'h0000;
  // Idle index is scrambled so a stale value cannot pass
  assign word_rd_o  = req_i;
  assign word_idx_o = req_i ? idx_i : ~last_q;
  always_ff @(posedge clk_i) begin
    last_q <= word_idx_o;
    if (req_i) begin
      pend_q <= idx_i;
    end
    if (word_ack_i && pend_q == idw_pkg::W_SUP1) begin
      sup1_q <= word_data_i;
    end
    if (word_ack_i && pend_q == idw_pkg::W_SUP2) begin
      sup2_q <= word_data_i;
    end
  end
  assign notify_ok_o = !((sup1_q == 16'h0000 && sup2_q == 16'h0000) ||
                         (sup1_q == 16'hffff && sup2_q == 16'hffff));
endmodule
`default_nettype wire

// ---- test/test_identify_data_upper_words.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_identify_data_upper_words;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        req = 1'b0, ack_o, word_rd, word_ack_o, udma_valid_o, notify_ok;
  logic [7:0]  adr_i = 8'h00, idx = 8'h00, word_idx, lastidx = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [15:0] word_data_o;
  logic [31:0] cfg [0:4] = '{default: 32'h0};
  logic [31:0] qw[$], qr[$], qm[$];
  int          n_errors = 0, n_checks = 0, nreads = 0, seed = 32'h21ba;

  initial forever #4 clk_i = ~clk_i;

  idw_core uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .word_rd_i(word_rd), .word_idx_i(word_idx), .word_data_o(word_data_o),
    .word_ack_o(word_ack_o), .udma_valid_o(udma_valid_o));
  idw_host host (.clk_i(clk_i), .req_i(req), .idx_i(idx), .word_ack_i(word_ack_o),
    .word_data_i(word_data_o), .word_rd_o(word_rd), .word_idx_o(word_idx),
    .notify_ok_o(notify_ok));

  // valid only when selection fits support
  function logic uv();
    uv = cfg[3][1:0] != 2'h0 && cfg[3][3:2] <= cfg[3][1:0];
  endfunction

  function logic [15:0] ew(input logic [7:0] i);
    logic [1:0] s, c;
    s = cfg[3][1:0];
    c = cfg[3][3:2];
    case (i)
      8'h50: ew = 16'h0006 | {11'h0, cfg[0][17:16], 3'h0};
      8'h51: ew = cfg[0][15:0];
      8'h52: ew = cfg[1][15:0] & 16'hf7ff;
      8'h53, 8'h56: ew = 16'h4000 | {15'h0, cfg[1][16]};
      8'h54, 8'h57: ew = 16'h4000;
      8'h55: ew = cfg[2][15:0];
      8'h58: ew = {5'h0, (c != 2'h0 && c <= s) ? 3'h1 << (c - 2'h1) : 3'h0, 5'h0,
                   3'h7 >> (2'h3 - s)};
      8'h80: ew = {7'h0, cfg[4][8], 3'h0, cfg[4][4:0]};
      8'h83: ew = {15'h0, ~cfg[4][16]};
      default: ew = 16'h0000;
    endcase
  endfunction

  function logic [31:0] fm(input logic [7:0] a);
    case (a)
      8'h00: fm = 32'h0003ffff;
      8'h04: fm = 32'h0001ffff;
      8'h08: fm = 32'h0000ffff;
      8'h0c: fm = 32'h0000000f;
      8'h10: fm = 32'h0001011f;
      8'h14: fm = 32'h00ffff01;
      default: fm = 32'hffffffff;
    endcase
  endfunction

  task chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task print_verdict;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (k == 20) n_errors++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    wb(1'b1, a, d, s);
    // Status is read-only and unmapped writes vanish
    if (a < 8'h14) cfg[a[4:2]] = (cfg[a[4:2]] & ~m) | (d & m & fm(a));
  endtask

  task rr(input logic [7:0] a);
    qm.push_back(fm(a));
    if (a < 8'h14) qr.push_back(cfg[a[4:2]]);
    else if (a == 8'h14) qr.push_back({8'h00, lastidx, nreads[7:0], 7'h00, uv()});
    else qr.push_back(32'h0);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask

  // Back-to-back record requests, one per cycle
  task rw(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      @(posedge clk_i);
      req <= 1'b1;
      idx <= 8'(i);
      qw.push_back({16'h0, ew(8'(i))});
      nreads++;
      lastidx = 8'(i);
    end
    @(posedge clk_i);
    req <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (word_ack_o === 1'b1) chk(qw.pop_front(), {16'h0, word_data_o});
    if (ack_o === 1'b1 && we_i === 1'b0) chk(qr.pop_front(), dat_o & qm.pop_front());
  end

  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end

  initial begin
    int i, j;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'h0, {31'h0, notify_ok});
    rw(0, 255);
    chk({31'h0, uv()}, {31'h0, udma_valid_o});
    chk(32'h1, {31'h0, notify_ok});
    for (i = 0; i < 10; i++) begin
      for (j = 0; j < 5; j++) wr(8'(j * 4), $random(seed), 4'hf);
      for (j = 0; j < 6; j++) rr(8'(j * 4));
      rw(80, 131);
    end
    for (i = 0; i < 16; i++) begin
      wr(idw_pkg::ADDR_UDMA, 32'(i), 4'hf);
      rw(88, 88);
      chk({31'h0, uv()}, {31'h0, udma_valid_o});
    end
    wr(idw_pkg::ADDR_SUPPORT, $random(seed), 4'h2);
    wr(idw_pkg::ADDR_STATUS, 32'hffffffff, 4'hf);
    wr(8'h20, 32'hffffffff, 4'hf);
    for (j = 0; j < 6; j++) rr(8'(j * 4));
    rr(8'h20);
    rw(80, 88);
    print_verdict;
  end
endmodule
`default_nettype wire
